// ==== include/ffetch_pkg.sv ====
// Purpose: shared constants and types for the flash instruction fetch block
// Assumes: one 250 MHz core clock, 32-bit words, byte addresses word aligned
// Notes:   counts of cycles are derived from times in ps
package ffetch_pkg;
  // word and address widths
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ADDR_W       = 32;
  // prefetch queue depth in instructions
  localparam int unsigned PFQ_DEPTH    = 8;
  localparam int unsigned PFQ_IDX_W    = 3;
  // general branch target entries; the interrupt entry is not counted here
  localparam int unsigned BTC_ENTRIES  = 15;
  localparam int unsigned BTC_IDX_W    = 4;
  localparam int unsigned BTC_WORDS    = 8;
  localparam int unsigned BTC_WORD_W   = 3;
  // index of the reserved interrupt entry
  localparam logic [BTC_IDX_W-1:0] BTC_IRQ_IDX = 4'hf;
  // flash burst word rate limit: least spacing between two words
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned FLASH_WORD_PS  = 10417;  // 96 MHz
  localparam int unsigned FLASH_GAP_CYC  =
    (FLASH_WORD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0]  FLASH_GAP_LOAD = 2'(FLASH_GAP_CYC - 1);
  // data fifo depth between flash and queue
  localparam int unsigned FIFO_DEPTH   = 4;
  // reset values
  localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
  // flash side states
  typedef enum logic [2:0] {
    FL_IDLE  = 3'b001,
    FL_BURST = 3'b010,
    FL_FILL  = 3'b100
  } ffetch_fl_state_type;
endpackage : ffetch_pkg

// ==== hdl/ffetch_fifo.sv ====
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   full and empty come from a separate fill count
`timescale 1ns/1ps
module ffetch_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } ffetch_fifo_st_type;
  ffetch_fifo_st_type st_ff, nxt_st;
  logic push, pop;
  // honest flags from the fill count
  assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.mem[st_ff.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // next state: a flush drops everything including a word in flight
  always_comb begin
    nxt_st = st_ff;
    if (flush) begin
      nxt_st.wr  = '0;
      nxt_st.rd  = '0;
      nxt_st.cnt = '0;
    end else begin
      if (push) begin
        nxt_st.mem[st_ff.wr] = in_data;
        nxt_st.wr            = st_ff.wr + 1'b1;
      end
      if (pop) begin
        nxt_st.rd = st_ff.rd + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : ffetch_fifo

// ==== hdl/ffetch_top.sv ====
// Purpose: instruction fetch path: flash burst link, prefetch queue, branch target cache
// Assumes: core asks one word at a time; literal reads flagged by the core
// Notes:   flash link is plain logic on the same clock, so no synchronisers
`timescale 1ns/1ps
// How it works
// [RULE_01] queue holds eight instructions ahead
// [RULE_02] keep prefetching whenever queue has room; code does not prefetch after reset until the first jump or literal read
// [RULE_03] one 32-bit word per flash beat, rate-limited
// [RULE_04] on jump, look up cache, then flush/reload
// [RULE_05] fifteen branch entries, eight words each
// [RULE_06] all entries compared at once, one cycle
// [RULE_07] hit serves cached words; flash resumes after
// [RULE_08] sixteenth entry holds interrupt vector read
// [RULE_09] literal reads bypass queue without flushing
// [RULE_10] sits in series on instruction port only
// [RULE_11] flash link is 32-bit sequential burst
// [RULE_12] replace least recently taken; reset invalidates
module ffetch_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // instruction tightly coupled port, core side
  input  wire logic        itcp_req,
  input  wire logic [31:0] itcp_addr,
  input  wire logic        itcp_literal,
  input  wire logic        itcp_irq_vec,
  output logic             itcp_ack,
  output logic      [31:0] itcp_rdata,
  // interrupt entry preload word
  input  wire logic [31:0] irq_vec_instr,
  // burst flash link
  output logic             fl_burst_start,
  output logic      [31:0] fl_addr,
  output logic             fl_next,
  input  wire logic        fl_valid,
  input  wire logic [31:0] fl_rdata
);
  localparam int unsigned NE = ffetch_pkg::BTC_ENTRIES;
  localparam int unsigned NW = ffetch_pkg::BTC_WORDS;

  // all block state
  typedef struct packed {
    ffetch_pkg::ffetch_fl_state_type      fl;
    logic [31:0]                          fetch_addr;  // next flash address
    logic [31:0]                          seq_addr;    // next expected core address
    logic [ffetch_pkg::PFQ_DEPTH-1:0][31:0] q;
    logic [ffetch_pkg::PFQ_IDX_W-1:0]     q_rd;
    logic [ffetch_pkg::PFQ_IDX_W-1:0]     q_wr;
    logic [ffetch_pkg::PFQ_IDX_W:0]       q_cnt;
    logic [NE-1:0]                        vld;
    logic [NE-1:0][31:0]                  tag;
    logic [NE-1:0][NW-1:0][31:0]          dat;
    logic [NE-1:0][3:0]                   age;         // 0 = newest
    logic                                 hit_act;     // serving from cache
    logic [3:0]                           hit_idx;
    logic [2:0]                           hit_wd;
    logic                                 fill_act;    // capturing a new entry
    logic [3:0]                           fill_idx;
    logic [2:0]                           fill_wd;
    logic [1:0]                           gap;         // beat spacing counter
    logic                                 lit_wait;    // literal beat pending
    logic                                 burst_start;
    logic [31:0]                          addr_out;    // registered flash address
    logic                                 ack;
    logic [31:0]                          rdata;
  } ffetch_st_type;

  ffetch_st_type st_ff, nxt_st;

  // fifo between flash and queue
  logic        ff_in_ready;
  logic        ff_out_valid;
  logic        ff_pop;
  logic [31:0] ff_out_data;
  logic        flush;

  // hit search over the general entries only; the interrupt word is answered apart
  logic        hit;
  logic [3:0]  hit_i;
  logic [3:0]  victim;

  // one parallel compare across every entry
  function automatic logic [4:0] lookup(input logic [NE-1:0] v,
                                        input logic [NE-1:0][31:0] t,
                                        input logic [31:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NE; i++) begin
      if (v[i] && t[i] == a) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction : lookup

  // replacement pick: any free entry, else oldest
  always_comb begin
    victim = 4'h0;
    for (int i = 0; i < NE; i++) begin
      if (st_ff.age[i] == 4'(NE - 1)) victim = 4'(i);
    end
    for (int i = NE - 1; i >= 0; i--) begin
      if (!st_ff.vld[i]) victim = 4'(i);
    end
  end

  assign {hit, hit_i} = lookup(st_ff.vld, st_ff.tag, itcp_addr); // see [RULE_06]

  // data path buffer from the flash link
  ffetch_fifo #(
    .WIDTH (32),
    .DEPTH (ffetch_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (fl_valid && !st_ff.lit_wait && !st_ff.burst_start),
    .in_ready  (ff_in_ready),
    .in_data   (fl_rdata),
    .out_valid (ff_out_valid),
    .out_ready (ff_pop),
    .out_data  (ff_out_data)
  );

  // queue takes a word when it has room; counts queued words only, not those still in the fifo
  assign ff_pop = ff_out_valid &&
                  (st_ff.q_cnt != 4'(ffetch_pkg::PFQ_DEPTH)); // see [RULE_01]

  // jump detection: non-literal, non-vector request away from sequential address
  // held request in its ack cycle must not look like a jump
  logic jump;
  assign jump  = itcp_req && !itcp_literal && !itcp_irq_vec &&
                 !st_ff.ack && !st_ff.lit_wait &&
                 itcp_addr != st_ff.seq_addr;
  // beat request: paced, never while a new burst address is being set up
  logic fl_next_c;
  assign fl_next_c = !st_ff.burst_start && (st_ff.gap == 2'h0) &&
                     (st_ff.lit_wait ||
                      (st_ff.fl == ffetch_pkg::FL_BURST && ff_in_ready));
  assign flush = jump; // see [RULE_04]

  // main next-state process
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.ack         = 1'b0;
    nxt_st.burst_start = 1'b0;
    if (st_ff.gap != 2'h0) nxt_st.gap = st_ff.gap - 2'h1;
    // pointer follows beats really taken, so a restart resumes exactly
    if (fl_valid && !st_ff.lit_wait && !st_ff.burst_start && ff_in_ready) begin
      nxt_st.fetch_addr = st_ff.fetch_addr + 32'h4;
    end

    // fifo word into the queue
    if (ff_pop) begin
      nxt_st.q[st_ff.q_wr] = ff_out_data;
      nxt_st.q_wr          = st_ff.q_wr + 3'h1;
      nxt_st.q_cnt         = st_ff.q_cnt + 4'h1;
      if (st_ff.fill_act) begin
        nxt_st.dat[st_ff.fill_idx][st_ff.fill_wd] = ff_out_data; // see [RULE_05]
        nxt_st.fill_wd = st_ff.fill_wd + 3'h1;
        if (st_ff.fill_wd == 3'(NW - 1)) begin
          nxt_st.fill_act            = 1'b0;
          nxt_st.vld[st_ff.fill_idx] = 1'b1;
        end
      end
    end

    // literal data beat returns straight to the core
    if (st_ff.lit_wait && fl_valid && !st_ff.burst_start) begin
      nxt_st.lit_wait    = 1'b0;
      nxt_st.ack         = 1'b1;
      nxt_st.rdata       = fl_rdata;
      nxt_st.burst_start = 1'b1;                // resume the stream
      nxt_st.fl          = ffetch_pkg::FL_BURST;
    end

    if (itcp_req && !st_ff.ack && !st_ff.lit_wait) begin
      if (itcp_irq_vec) begin
        nxt_st.ack   = 1'b1;                    // see [RULE_08]
        nxt_st.rdata = irq_vec_instr;
      end else if (itcp_literal) begin
        // one-off read; queue contents stay untouched
        nxt_st.lit_wait    = 1'b1;              // see [RULE_09]
        nxt_st.burst_start = 1'b1;
      end else if (jump) begin
        nxt_st.q_rd    = 3'h0;
        nxt_st.q_wr    = 3'h0;
        nxt_st.q_cnt   = 4'h0;
        nxt_st.hit_act = hit;
        nxt_st.burst_start = 1'b1;
        nxt_st.fl          = ffetch_pkg::FL_BURST;
        if (hit) begin
          nxt_st.ack        = 1'b1;             // see [RULE_07]
          nxt_st.rdata      = st_ff.dat[hit_i][0];
          nxt_st.hit_idx    = hit_i;
          nxt_st.hit_wd     = 3'h1;
          nxt_st.seq_addr   = itcp_addr + 32'h4;
          nxt_st.fetch_addr = itcp_addr + 32'(NW * 4);
          nxt_st.fill_act   = 1'b0;
          for (int i = 0; i < NE; i++) begin    // see [RULE_12]
            if (st_ff.age[i] < st_ff.age[hit_i]) nxt_st.age[i] = st_ff.age[i] + 4'h1;
          end
          nxt_st.age[hit_i] = 4'h0;
        end else begin
          nxt_st.seq_addr    = itcp_addr;
          nxt_st.fetch_addr  = itcp_addr;
          nxt_st.fill_act    = 1'b1;
          nxt_st.fill_idx    = victim;
          nxt_st.fill_wd     = 3'h0;
          nxt_st.vld[victim] = 1'b0;
          nxt_st.tag[victim] = itcp_addr;
          for (int i = 0; i < NE; i++) begin    // see [RULE_12]
            if (st_ff.age[i] < st_ff.age[victim]) nxt_st.age[i] = st_ff.age[i] + 4'h1;
          end
          nxt_st.age[victim] = 4'h0;
        end
      end else if (st_ff.hit_act) begin
        // remaining cached words while flash refills
        nxt_st.ack      = 1'b1;
        nxt_st.rdata    = st_ff.dat[st_ff.hit_idx][st_ff.hit_wd];
        nxt_st.hit_wd   = st_ff.hit_wd + 3'h1;
        nxt_st.seq_addr = st_ff.seq_addr + 32'h4;
        if (st_ff.hit_wd == 3'(NW - 1)) nxt_st.hit_act = 1'b0;
      end else if (st_ff.q_cnt != 4'h0) begin
        // sequential word from the queue
        nxt_st.ack      = 1'b1;
        nxt_st.rdata    = st_ff.q[st_ff.q_rd];
        nxt_st.q_rd     = st_ff.q_rd + 3'h1;
        nxt_st.q_cnt    = nxt_st.q_cnt - 4'h1;
        nxt_st.seq_addr = st_ff.seq_addr + 32'h4;
      end
    end

    // look ahead on flash while room and rate allow
    if (fl_next_c) begin                          // see [RULE_02]
      nxt_st.gap = ffetch_pkg::FLASH_GAP_LOAD;    // see [RULE_03]
    end
    // address seen by the flash with the next burst start
    nxt_st.addr_out = nxt_st.lit_wait ? itcp_addr : nxt_st.fetch_addr;
  end

  // state register; reset invalidates every cache entry
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff            <= '0;
      st_ff.fl         <= ffetch_pkg::FL_IDLE;
      st_ff.fetch_addr <= ffetch_pkg::RST_ADDR;
      st_ff.seq_addr   <= ffetch_pkg::RST_ADDR;
      st_ff.addr_out   <= ffetch_pkg::RST_ADDR;
      st_ff.burst_start <= 1'b1;
      for (int i = 0; i < NE; i++) st_ff.age[i] <= 4'(i); // see [RULE_12]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs from flip-flops except fl_next, which is combinational; flash only on the instruction path
  assign itcp_ack       = st_ff.ack;        // see [RULE_10]
  assign itcp_rdata     = st_ff.rdata;
  assign fl_burst_start = st_ff.burst_start; // see [RULE_11]
  assign fl_addr        = st_ff.addr_out;
  assign fl_next        = fl_next_c;
endmodule : ffetch_top

// ==== dv/ffetch_fetch_monitor.sv ====
// Purpose: port checker for the fetch path
// Assumes: flash word at byte address a is fw(a)
// Notes:   sees only the top ports
`timescale 1ns/1ps
module ffetch_fetch_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // core port
  input wire logic        itcp_req,
  input wire logic [31:0] itcp_addr,
  input wire logic        itcp_literal,
  input wire logic        itcp_irq_vec,
  input wire logic        itcp_ack,
  input wire logic [31:0] itcp_rdata,
  input wire logic [31:0] irq_vec_instr,
  // flash link
  input wire logic        fl_burst_start,
  input wire logic [31:0] fl_addr,
  input wire logic        fl_next,
  input wire logic        fl_valid,
  input wire logic [31:0] fl_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // scrambled word so stale data never matches
  function automatic logic [31:0] fw(input logic [31:0] a);
    return {a[15:0], a[31:16]} ^ 32'h5ac3_3c5a;
  endfunction : fw
  ack_pulse_a: assert property (itcp_ack |=> !itcp_ack)
    else $error("ack wider than one cycle");
  ack_cause_a: assert property (itcp_ack |-> $past(itcp_req))
    else $error("ack without request");
  req_answer_a: assert property (itcp_req && !itcp_ack |-> ##[0:120] itcp_ack)
    else $error("request never answered");
  fetch_data_a: assert property (itcp_ack && !$past(itcp_irq_vec)
    |-> itcp_rdata == fw($past(itcp_addr))) else $error("wrong fetch word");
  irq_entry_a: assert property (itcp_req && itcp_irq_vec && !itcp_ack && !$past(itcp_ack)
    |=> itcp_ack && itcp_rdata == $past(irq_vec_instr)) else $error("slow vector read");
  literal_ack_a: assert property (itcp_ack && $past(itcp_literal) |-> $past(fl_valid))
    else $error("literal answered without beat");
  burst_align_a: assert property (fl_burst_start |-> fl_addr[1:0] == 2'h0)
    else $error("burst address not word aligned");
  beat_space_a: assert property (fl_valid |=> !fl_next)
    else $error("beat taken too fast");
  cover property (fl_burst_start ##[1:20] fl_valid);
  cover property (itcp_ack && $past(itcp_literal));
  cover property (itcp_req && itcp_irq_vec ##1 itcp_ack);
endmodule : ffetch_fetch_monitor

// ==== dv/ffetch_flash_model.sv ====
// Purpose: flash die model for the fetch path
// Assumes: word at byte address a is fw(a)
// Notes:   slow adds three idle cycles per beat
`timescale 1ns/1ps
module ffetch_flash_model #(
  parameter int GAP = 3  // cycles per beat at full rate
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // pace select
  input  wire logic        slow,
  // burst link
  input  wire logic        burst_start,
  input  wire logic [31:0] addr,
  input  wire logic        next,
  output logic             valid,
  output logic      [31:0] rdata
);
  logic [31:0] ptr_ff;   // next beat address
  int          wait_ff;  // idle cycles left
  function automatic logic [31:0] fw(input logic [31:0] a);
    return {a[15:0], a[31:16]} ^ 32'h5ac3_3c5a;
  endfunction : fw
  // beats only when asked and paced; idle data inverted, never held
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid   <= 1'b0;
      rdata   <= 32'h0;
      ptr_ff  <= 32'h0;
      wait_ff <= 0;
    end else if (burst_start) begin
      valid   <= 1'b0;
      rdata   <= ~rdata;
      ptr_ff  <= addr;
      wait_ff <= slow ? GAP + 2 : GAP - 1;
    end else if (next && wait_ff == 0) begin
      valid   <= 1'b1;
      rdata   <= fw(ptr_ff);
      ptr_ff  <= ptr_ff + 32'h4;
      wait_ff <= slow ? GAP + 2 : GAP - 1;
    end else begin
      valid   <= 1'b0;
      rdata   <= ~rdata;
      wait_ff <= (wait_ff == 0) ? 0 : wait_ff - 1;
    end
  end
endmodule : ffetch_flash_model

// ==== dv/ffetch_top_test.sv ====
// Purpose: self-checking bench for the fetch path
// Assumes: lat of 2 edges in fetch() is a one-cycle answer
// Notes:   flash pace varied at random per request
`timescale 1ns/1ps
module ffetch_top_test;
  // stimulus
  logic        core_clk, fl_slow = 1'b0, rst = 1'b1;
  logic        itcp_req = 1'b0, itcp_literal = 1'b0, itcp_irq_vec = 1'b0;
  logic [31:0] itcp_addr = 32'h0, irq_vec_instr = 32'h0;
  // observed
  logic        itcp_ack, fl_burst_start, fl_next, fl_valid;
  logic [31:0] itcp_rdata, fl_addr, fl_rdata, exp_w;
  logic [31:0] exp_q[$];
  int          errors = 0, checked = 0, seed = 41823, lat, cyc = 0;
  ffetch_top uut (.core_clk(core_clk), .rst(rst), .itcp_req(itcp_req),
    .itcp_addr(itcp_addr), .itcp_literal(itcp_literal), .itcp_irq_vec(itcp_irq_vec),
    .itcp_ack(itcp_ack), .itcp_rdata(itcp_rdata), .irq_vec_instr(irq_vec_instr),
    .fl_burst_start(fl_burst_start), .fl_addr(fl_addr), .fl_next(fl_next),
    .fl_valid(fl_valid), .fl_rdata(fl_rdata));
  ffetch_flash_model flash (.core_clk(core_clk), .rst(rst), .slow(fl_slow),
    .burst_start(fl_burst_start), .addr(fl_addr), .next(fl_next),
    .valid(fl_valid), .rdata(fl_rdata));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] fw(input logic [31:0] a);
    return {a[15:0], a[31:16]} ^ 32'h5ac3_3c5a;
  endfunction : fw
  // one request held until ack; expected word noted first
  task automatic fetch(input logic [31:0] a, input logic lit, input logic irq);
    @(posedge core_clk);
    itcp_req <= 1'b1;
    itcp_addr <= a;
    itcp_literal <= lit;
    itcp_irq_vec <= irq;
    fl_slow <= 1'($random(seed));
    exp_q.push_back(irq ? irq_vec_instr : fw(a));
    lat = 0;
    do begin
      @(posedge core_clk);
      lat++;
    end while (itcp_ack !== 1'b1 && lat < 300);
    itcp_req <= 1'b0;
    itcp_literal <= 1'b0;
    itcp_irq_vec <= 1'b0;
  endtask : fetch
  task automatic chk_lat(input logic fast);
    checked++;
    if ((lat == 2) !== fast) begin
      errors++;
      $display("[FAIL] %0t latency %0d", $time, lat);
    end
  endtask : chk_lat
  // jump to base, judge the first answer, then run on sequentially
  task automatic jump(input logic [31:0] base, input int n, input logic fast);
    fetch(base, 1'b0, 1'b0);
    chk_lat(fast);
    for (int i = 1; i < n; i++) fetch(base + 32'(4 * i), 1'b0, 1'b0);
  endtask : jump
  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // oldest note against each ack
  always @(posedge core_clk) begin
    if (!rst && itcp_ack === 1'b1) begin
      exp_w = exp_q.pop_front();
      checked++;
      if (itcp_rdata !== exp_w) begin
        errors++;
        $display("[FAIL] %0t rdata %h want %h", $time, itcp_rdata, exp_w);
      end
    end
  end
  // hang guard, far above the under two thousand cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t watchdog", $time);
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    jump(32'h100, 12, 1'b0);
    repeat (40) @(posedge core_clk);
    fetch(32'h0008_0000 | (32'($random(seed)) & 32'hfffc), 1'b1, 1'b0);
    fetch(32'h130, 1'b0, 1'b0);
    chk_lat(1'b1);
    irq_vec_instr <= 32'($random(seed));
    fetch(32'h18, 1'b0, 1'b1);
    chk_lat(1'b1);
    for (int k = 0; k < 16; k++) jump(32'h4_0000 + 32'(k * 256), 8, 1'b0);
    jump(32'h4_0100, 12, 1'b1);
    jump(32'h4_0f00, 8, 1'b1);
    jump(32'h4_0000, 8, 1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    exp_q.delete();
    rst <= 1'b0;
    jump(32'h4_0f00, 8, 1'b0);
    final_report();
  end
endmodule : ffetch_top_test
bind ffetch_top ffetch_fetch_monitor mon (.core_clk(core_clk), .rst(rst),
  .itcp_req(itcp_req), .itcp_addr(itcp_addr), .itcp_literal(itcp_literal),
  .itcp_irq_vec(itcp_irq_vec), .itcp_ack(itcp_ack), .itcp_rdata(itcp_rdata),
  .irq_vec_instr(irq_vec_instr), .fl_burst_start(fl_burst_start), .fl_addr(fl_addr),
  .fl_next(fl_next), .fl_valid(fl_valid), .fl_rdata(fl_rdata));
